// >>> design/fcl_pkg.sv
// package of constants for the flash configuration register and read-latency link
// assumes: the host end makes the serial clock and the device end samples it, each with its own 125 MHz system clock
// Notes on behaviour
// R1: plain read up to 50 MHz, no latency
// R2: code 10b: fast 133, dual/quad 104
// R3: host may keep faster code when slower
// R4: standard variant: only quad I/O has mode
// R5: enhanced variant adds mode for dual, ddr
// R6: ddr with 5+ dummy may drive pattern
// R7: SDR standard mode/dummy table per code
// R8: DDR standard mode/dummy table per code
// R9: SDR enhanced: dual I/O mode 4, dummy 0/0/1/2
// R10: DDR enhanced mode/dummy table per code
// R11: host never issues unsupported read
// R12: origin bit: 0 top, 1 bottom
// R13: one-time bits cannot return to zero; error
// R14: host sets one-time bits before array use
// R15: volatile protect field resets to 111
// R16: param location bit: 1 top, 0 bottom
// R17: uniform sectors ignore param location
// R18: origin and param location independent
// R19: quad bit repurposes protect and pause pins
// R20: host sets quad before quad commands
// R21: lock bit freezes protect, origin, location
// R22: lock clears only on hard reset
// R23: latency code selects mode and dummy cycles
// R24: lookup by opcode, code and variant
package fcl_pkg;
  // ----------------------------------------------------------------
  // config register fields
  // ----------------------------------------------------------------
  localparam int CFG_LAT_HI    = 7;
  localparam int CFG_LAT_LO    = 6;
  localparam int CFG_ORIGIN    = 5;
  localparam int CFG_VOLAT     = 3;
  localparam int CFG_PLOC      = 2;
  localparam int CFG_QUAD      = 1;
  localparam int CFG_LOCK      = 0;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [7:0] CFG_OTP_MASK = 8'h2C;
  localparam logic [2:0] PROT_VOL_RESET = 3'h7;
  localparam logic [2:0] PROT_SHIP      = 3'h0;
  localparam int STAT_PERR     = 6;
  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_REGS = 8'h01;
  localparam logic [7:0] OP_READ_CFG   = 8'h35;
  localparam logic [7:0] OP_READ_STAT  = 8'h05;
  localparam logic [7:0] OP_SOFT_RESET = 8'hF0;
  // ----------------------------------------------------------------
  // link timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 125;
  localparam int SCK_HALF_NS   = 40;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS * CLK_MHZ) / 1000;
  localparam int DLP_MIN_DUMMY = 5;

  // mode (hi nibble) and dummy (lo nibble) for an opcode; 8'hFF = not listed
  function automatic logic [7:0] lat_lookup(input logic [7:0] op, input logic [1:0] lc, input logic enh);
    logic [1:0] i;
    i = lc + 2'h1; // order 11,00,01,10 -> 0..3
    case (op)
      8'h03, 8'h13: lat_lookup = 8'h00;                          // R1
      8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C:
        lat_lookup = (i == 2'h0) ? 8'h00 : 8'h08;                 // R7 R2
      8'hBB, 8'hBC:
        lat_lookup = enh ? {4'h4, (i < 2'h2) ? 4'h0 : {2'h0, i - 2'h1}}  // R9 R5
                         : {4'h0, 4'h4 + {2'h0, (i == 2'h0) ? 2'h0 : i - 2'h1}}; // R4 R7
      8'hEB, 8'hEC:
        lat_lookup = {4'h2, (i == 2'h0) ? 4'h1 : (i == 2'h3) ? 4'h5 : 4'h4};
      8'h0D, 8'h0E:
        lat_lookup = enh ? {4'h4, (i == 2'h0) ? 4'h1 : (i == 2'h1) ? 4'h2 : {2'h0, i} + 4'h2} // R10
                         : {4'h0, 4'h4 + {2'h0, i}};               // R8
      8'hBD, 8'hBE:
        lat_lookup = enh ? {4'h2, (i == 2'h0) ? 4'h2 : 4'h3 + {2'h0, i}}
                         : {4'h0, (i == 2'h0) ? 4'h4 : 4'h5 + {2'h0, i}};
      8'hED, 8'hEE:
        lat_lookup = {4'h1, (i == 2'h0) ? 4'h3 : 4'h5 + {2'h0, i}};
      default: lat_lookup = 8'hFF;
    endcase
  endfunction

  function automatic logic is_ddr(input logic [7:0] op);
    is_ddr = (op == 8'h0D) || (op == 8'h0E) || (op == 8'hBD) || (op == 8'hBE) ||
             (op == 8'hED) || (op == 8'hEE);
  endfunction
endpackage

// >>> design/fcl_link_if.sv
// serial link between host and flash configuration end
// assumes: the bench gives each data pin a single driver and leaves the enables unused
`timescale 1ns/10ps
interface fcl_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  modport host (output sck, output cs_n, output mosi, input miso, input miso_oe_n);
  modport dev  (input sck, input cs_n, input mosi, output miso, output miso_oe_n);
endinterface

// >>> design/fcl_dev.sv
// device end: config register, protect field, latency lookup
// assumes: serial mode 0, msb first, one byte of opcode then payload
`timescale 1ns/10ps
module fcl_dev #(
  parameter bit UNIFORM = 1'b0,
  parameter bit ENHANCED = 1'b0
) (
  input  wire logic       CLOCK,
  input  wire logic       SYS_RST,
  input  wire logic       POWER_ON,
  input  wire logic       WP_N_PIN,
  input  wire logic       HOLD_N_PIN,
  input  wire logic [7:0] READ_OP,
  fcl_link_if.dev         LINK,
  output logic [7:0]      CFG,
  output logic [2:0]      PROT,
  output logic            PROG_ERR,
  output logic [3:0]      MODE_CYC,
  output logic [3:0]      DUMMY_CYC,
  output logic            READ_OK,
  output logic            LEARN_OK,
  output logic            PROT_TOP,
  output logic            PARAM_TOP,
  output logic            WP_N_EFF,
  output logic            HOLD_N_EFF
);
  // ----------------------------------------------------------------
  // pin synchronisers: three stages, change when last two agree
  // ----------------------------------------------------------------
  logic [2:0] sck_s_r, cs_s_r, mo_s_r;
  logic       sck_q_r, cs_q_r, mo_q_r, sck_prev_r;
  always_ff @(posedge CLOCK)
  begin
    sck_s_r <= {sck_s_r[1:0], LINK.sck};
    cs_s_r  <= {cs_s_r[1:0], LINK.cs_n};
    mo_s_r  <= {mo_s_r[1:0], LINK.mosi};
    if (sck_s_r[2] == sck_s_r[1]) sck_q_r <= sck_s_r[2];
    if (cs_s_r[2] == cs_s_r[1]) cs_q_r <= cs_s_r[2];
    if (mo_s_r[2] == mo_s_r[1]) mo_q_r <= mo_s_r[2];
    sck_prev_r <= sck_q_r;
  end
  wire rise = sck_q_r & ~sck_prev_r;
  wire fall = ~sck_q_r & sck_prev_r;

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  logic [4:0]  bit_cnt_r;
  logic [23:0] sh_r;
  logic [7:0]  op_r, out_r;
  // register state is declared here because the read answer below loads from it
  logic [7:0]  cfg_r, cfg_nxt;
  logic [2:0]  prot_r;
  logic        perr_r, otp_viol;
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST || cs_q_r)
    begin
      bit_cnt_r <= 5'h00;
      sh_r      <= 24'h000000;
    end
    else if (rise && bit_cnt_r != 5'h18)
    begin
      sh_r      <= {sh_r[22:0], mo_q_r};
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST) op_r <= 8'h00;
    else if (rise && bit_cnt_r == 5'h07) op_r <= {sh_r[6:0], mo_q_r};
  end
  // read answer loads at opcode, shifts out on falling edges
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST) out_r <= 8'h00;
    else if (rise && bit_cnt_r == 5'h07)
      out_r <= ({sh_r[6:0], mo_q_r} == fcl_pkg::OP_READ_CFG) ? cfg_r :
               {1'b0, perr_r, 1'b0, prot_r, 2'h0};
    else if (fall && bit_cnt_r > 5'h08) out_r <= {out_r[6:0], 1'b0};
  end
  assign LINK.miso      = out_r[7];
  assign LINK.miso_oe_n = cs_q_r | (op_r != fcl_pkg::OP_READ_CFG && op_r != fcl_pkg::OP_READ_STAT)
                          | (bit_cnt_r < 5'h08);

  // end of frame: cs rising with a full write payload
  logic cs_prev_r;
  always_ff @(posedge CLOCK) cs_prev_r <= cs_q_r;
  wire frame_end = cs_q_r & ~cs_prev_r;
  wire do_write  = frame_end && op_r == fcl_pkg::OP_WRITE_REGS && bit_cnt_r == 5'h18;
  wire do_srst   = frame_end && op_r == fcl_pkg::OP_SOFT_RESET && bit_cnt_r == 5'h08;
  wire [7:0] new_stat = sh_r[15:8];
  wire [7:0] new_cfg  = sh_r[7:0];

  // ----------------------------------------------------------------
  // config register, protect field, error flag
  // ----------------------------------------------------------------
  always_comb
  begin
    cfg_nxt  = new_cfg;
    otp_viol = |(cfg_r & fcl_pkg::CFG_OTP_MASK & ~new_cfg);             // R13
    cfg_nxt  = cfg_nxt | (cfg_r & fcl_pkg::CFG_OTP_MASK);                // R13
    cfg_nxt[4] = 1'b0;
    if (cfg_r[fcl_pkg::CFG_LOCK])
    begin                                                               // R21
      cfg_nxt[fcl_pkg::CFG_ORIGIN] = cfg_r[fcl_pkg::CFG_ORIGIN];
      cfg_nxt[fcl_pkg::CFG_PLOC]   = cfg_r[fcl_pkg::CFG_PLOC];
      cfg_nxt[fcl_pkg::CFG_LOCK]   = 1'b1;                                 // R22
    end
    if (UNIFORM) cfg_nxt[fcl_pkg::CFG_PLOC] = cfg_r[fcl_pkg::CFG_PLOC];  // R17
  end
  // power-on and hard reset both clear lock; soft reset keeps it
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST && POWER_ON) cfg_r <= fcl_pkg::CFG_RESET;
    else if (SYS_RST) cfg_r <= cfg_r & ~8'h01;                            // R22
    else if (do_write) cfg_r <= cfg_nxt;
  end
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST && POWER_ON) prot_r <= fcl_pkg::PROT_SHIP;
    else if (SYS_RST || do_srst)
    begin
      if (cfg_r[fcl_pkg::CFG_VOLAT]) prot_r <= fcl_pkg::PROT_VOL_RESET;   // R15
    end
    else if (do_write && !cfg_r[fcl_pkg::CFG_LOCK]) prot_r <= new_stat[4:2]; // R21
  end
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST) perr_r <= 1'b0;
    else if (do_write && otp_viol) perr_r <= 1'b1;                       // R13
  end

  // ----------------------------------------------------------------
  // latency lookup and pin roles
  // ----------------------------------------------------------------
  logic [7:0] lat;
  assign lat = fcl_pkg::lat_lookup(READ_OP, cfg_r[7:6], ENHANCED);       // R24 R23
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      MODE_CYC <= 4'h0;
      DUMMY_CYC <= 4'h0;
      READ_OK <= 1'b0;
      LEARN_OK <= 1'b0;
    end
    else
    begin
      MODE_CYC  <= lat[7:4];
      DUMMY_CYC <= lat[3:0];
      READ_OK   <= lat != 8'hFF;
      LEARN_OK  <= fcl_pkg::is_ddr(READ_OP) && lat[3:0] >= 4'(fcl_pkg::DLP_MIN_DUMMY); // R6
    end
  end
  assign CFG        = cfg_r;
  assign PROT       = prot_r;
  assign PROG_ERR   = perr_r;
  assign PROT_TOP   = ~cfg_r[fcl_pkg::CFG_ORIGIN];                       // R12 R18
  assign PARAM_TOP  = cfg_r[fcl_pkg::CFG_PLOC] & ~UNIFORM;               // R16 R18
  assign WP_N_EFF   = cfg_r[fcl_pkg::CFG_QUAD] | WP_N_PIN;               // R19
  assign HOLD_N_EFF = cfg_r[fcl_pkg::CFG_QUAD] | HOLD_N_PIN;             // R19
endmodule

// >>> design/fcl_host.sv
// host end: sends one command frame, shifts in the answer byte
// assumes: user keeps payload steady while BUSY
`timescale 1ns/10ps
module fcl_host (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        START,
  input  wire logic [7:0]  OPCODE,
  input  wire logic [15:0] PAYLOAD,
  input  wire logic [1:0]  NBYTES,
  fcl_link_if.host         LINK,
  output logic             BUSY,
  output logic             DONE,
  output logic [7:0]       RDATA
);
  typedef enum logic [1:0] {IDLE = 2'b00, LOW = 2'b01, HIGH = 2'b11, ENDF = 2'b10} fcl_hst_e;
  fcl_hst_e    st_r;
  logic [4:0]  div_r, bits_r;
  logic [23:0] sh_r;
  logic [7:0]  rd_r;
  wire  tick = div_r == 5'(fcl_pkg::SCK_HALF_CYC - 1);
  // ----------------------------------------------------------------
  // clock divider and frame sequencer; host keeps R3 R11 R14 R20 by usage
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST || st_r == IDLE || tick) div_r <= 5'h00;
    else div_r <= div_r + 5'h01;
  end
  always_ff @(posedge CLOCK)
  begin
    DONE <= 1'b0;
    if (SYS_RST)
    begin
      st_r <= IDLE;
      bits_r <= 5'h00;
      sh_r <= 24'h000000;
      rd_r <= 8'h00;
    end
    else
      case (st_r)
        IDLE: if (START)
        begin
          sh_r   <= {OPCODE, PAYLOAD};
          bits_r <= {NBYTES, 3'h0} + 5'h08;
          st_r   <= LOW;
        end
        LOW: if (tick)
        begin
          st_r <= HIGH;
        end
        // sample at the end of the high phase: the far end shifts on its
        // delayed view of the falling edge, which lands on the end of low
        HIGH: if (tick)
        begin
          rd_r   <= {rd_r[6:0], LINK.miso};
          sh_r   <= {sh_r[22:0], 1'b0};
          bits_r <= bits_r - 5'h01;
          st_r   <= (bits_r == 5'h01) ? ENDF : LOW;
        end
        ENDF: if (tick)
        begin
          DONE <= 1'b1;
          st_r <= IDLE;
        end
        default: st_r <= IDLE;
      endcase
  end
  assign LINK.sck  = st_r == HIGH;
  assign LINK.cs_n = st_r == IDLE;
  assign LINK.mosi = sh_r[23];
  assign BUSY      = st_r != IDLE;
  assign RDATA     = rd_r;
endmodule

// >>> verification/fcl_link_properties.sv
// assertions for the config-register end, watching the link and the end's ports
// assumes: one instance in tb_top, device built with uniform sectors off
`timescale 1ns/10ps
module fcl_link_properties (
  input wire logic       CLOCK,
  input wire logic       SYS_RST,
  input wire logic       cs_n,
  input wire logic [7:0] CFG,
  input wire logic [7:0] READ_OP,
  input wire logic [3:0] MODE_CYC,
  input wire logic [3:0] DUMMY_CYC,
  input wire logic       LEARN_OK,
  input wire logic       PROT_TOP,
  input wire logic       PARAM_TOP,
  input wire logic       WP_N_PIN,
  input wire logic       HOLD_N_PIN,
  input wire logic       WP_N_EFF,
  input wire logic       HOLD_N_EFF
);
  // ----------------------------------------------------------------
  // one clock domain, reset disables everything
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  a_quad_pins_idle: assert property (CFG[1] |-> WP_N_EFF && HOLD_N_EFF)
    else $error("quad mode leaves a pin function active");
  a_pins_pass: assert property (!CFG[1] |-> WP_N_EFF == WP_N_PIN && HOLD_N_EFF == HOLD_N_PIN)
    else $error("pin functions not passed through");
  a_origin_map: assert property (PROT_TOP == !CFG[5])
    else $error("protect origin mismatch");
  a_param_map: assert property (PARAM_TOP == CFG[2])
    else $error("parameter location mismatch");
  a_otp_no_clear: assert property (!($fell(CFG[5]) || $fell(CFG[3]) || $fell(CFG[2])))
    else $error("one-time bit returned to zero");
  a_lock_sticky: assert property (!$fell(CFG[0]))
    else $error("lock cleared without hard reset");
  a_lock_freeze: assert property ($past(CFG[0]) |-> $stable(CFG[5]) && $stable(CFG[2]))
    else $error("frozen bit changed");
  a_cfg_frame_end: assert property (!$stable(CFG) |-> cs_n)
    else $error("config changed inside a frame");
  a_learn_dummy: assert property (LEARN_OK |-> DUMMY_CYC >= 4'h5)
    else $error("learning pattern with too few dummy cycles");
  a_plain_read_lat: assert property ($past(READ_OP) == 8'h03 |-> {MODE_CYC, DUMMY_CYC} == 8'h00)
    else $error("plain read has latency");
endmodule

// >>> verification/tb_top.sv
// self-checking bench: host end and two config ends (standard, enhanced) on one link
// assumes: 125 MHz clock; the host end makes the link clock
`timescale 1ns/10ps
module tb_top;
  logic        clock    = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        power_on = 1'b1;
  logic        wp_n     = 1'b1;
  logic        hold_n   = 1'b1;
  logic [7:0]  read_op  = 8'h03;
  logic        start    = 1'b0;
  logic [7:0]  opcode   = 8'h00;
  logic [15:0] payload  = 16'h0000;
  logic [1:0]  nbytes   = 2'h0;
  logic        done;
  logic [7:0]  rdata;
  logic [7:0]  cfg;
  logic [2:0]  prot;
  logic        prog_err, read_ok, learn_ok, prot_top, param_top, wp_eff, hold_eff;
  logic [3:0]  mode_cyc, dummy_cyc, mode_e, dummy_e;
  int          error_cnt = 0;
  int          tests_run = 0;
  // rows per opcode: bytes {mode,dummy} for codes 11,00,01,10; last entry is unlisted
  logic [7:0]  ops [10]   = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'h0D, 8'hBD, 8'hED, 8'h02};
  logic [31:0] lat_s [10] = '{32'h0, 32'h080808, 32'h080808, 32'h080808, 32'h04040506, 32'h21242425,
                              32'h04050607, 32'h04060708, 32'h13161718, 32'h0};
  logic [31:0] lat_e [10] = '{32'h0, 32'h080808, 32'h080808, 32'h080808, 32'h40404142, 32'h21242425,
                              32'h41424445, 32'h22242526, 32'h13161718, 32'h0};

  always #4 clock = ~clock;

  // ----------------------------------------------------------------
  // the ends; the enhanced end only listens, so its data pin stays off the link
  // ----------------------------------------------------------------
  fcl_link_if lk ();
  fcl_link_if lk2 ();
  assign lk2.sck  = lk.sck;
  assign lk2.cs_n = lk.cs_n;
  assign lk2.mosi = lk.mosi;
  fcl_host fcl_host_i (.CLOCK(clock), .SYS_RST(sys_rst), .START(start), .OPCODE(opcode), .PAYLOAD(payload),
    .NBYTES(nbytes), .LINK(lk.host), .BUSY(), .DONE(done), .RDATA(rdata));
  fcl_dev fcl_dev_i (.CLOCK(clock), .SYS_RST(sys_rst), .POWER_ON(power_on), .WP_N_PIN(wp_n), .HOLD_N_PIN(hold_n),
    .READ_OP(read_op), .LINK(lk.dev), .CFG(cfg), .PROT(prot), .PROG_ERR(prog_err), .MODE_CYC(mode_cyc),
    .DUMMY_CYC(dummy_cyc), .READ_OK(read_ok), .LEARN_OK(learn_ok), .PROT_TOP(prot_top), .PARAM_TOP(param_top),
    .WP_N_EFF(wp_eff), .HOLD_N_EFF(hold_eff));
  fcl_dev #(.ENHANCED(1'b1)) fcl_dev_i2 (.CLOCK(clock), .SYS_RST(sys_rst), .POWER_ON(power_on), .WP_N_PIN(wp_n),
    .HOLD_N_PIN(hold_n), .READ_OP(read_op), .LINK(lk2.dev), .CFG(), .PROT(), .PROG_ERR(), .MODE_CYC(mode_e),
    .DUMMY_CYC(dummy_e), .READ_OK(), .LEARN_OK(), .PROT_TOP(), .PARAM_TOP(), .WP_N_EFF(), .HOLD_N_EFF());
  fcl_link_properties fcl_link_properties_i (.CLOCK(clock), .SYS_RST(sys_rst), .cs_n(lk.cs_n), .CFG(cfg),
    .READ_OP(read_op), .MODE_CYC(mode_cyc), .DUMMY_CYC(dummy_cyc), .LEARN_OK(learn_ok), .PROT_TOP(prot_top),
    .PARAM_TOP(param_top), .WP_N_PIN(wp_n), .HOLD_N_PIN(hold_n), .WP_N_EFF(wp_eff), .HOLD_N_EFF(hold_eff));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one frame; waits for done, then lets the end's registers settle
  task automatic cmd(input logic [7:0] op, input logic [15:0] pl, input logic [1:0] nb);
    int n;
    @(posedge clock);
    #1;
    opcode = op;
    payload = pl;
    nbytes = nb;
    start = 1'b1;
    @(posedge clock);
    #1;
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 1000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 1000)
      chk(8'h01, 8'h00);
    repeat (8) @(posedge clock);
    #1;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int i;
    repeat (12) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    power_on = 1'b0;
    chk({prog_err, 4'h0, prot}, 8'h00);
    chk(cfg, 8'h00);
    // every latency code against one opcode of each listed read pair, both variants
    for (int c = 0; c < 4; c++)
    begin
      cmd(8'h01, {8'h00, c[1:0], 6'h00}, 2'h2);
      i = (c + 1) % 4;
      for (int k = 0; k < 10; k++)
      begin
        read_op = ops[k];
        repeat (2) @(posedge clock);
        #1;
        chk({7'h00, read_ok}, {7'h00, k != 9});
        if (k < 9)
        begin
          chk({mode_cyc, dummy_cyc}, lat_s[k][8*(3-i) +: 8]);
          chk({mode_e, dummy_e}, lat_e[k][8*(3-i) +: 8]);
          chk({7'h00, learn_ok}, {7'h00, k > 5 && lat_s[k][8*(3-i) +: 4] >= 4'h5});
        end
      end
    end
    wp_n = 1'b0;
    hold_n = 1'b0;
    cmd(8'h01, 16'h0002, 2'h2);
    chk({6'h00, wp_eff, hold_eff}, 8'h03);
    cmd(8'h01, 16'h0000, 2'h2);
    chk({6'h00, wp_eff, hold_eff}, 8'h00);
    // reserved bit written too; then two one-time bits are asked to clear
    cmd(8'h01, 16'h1438, 2'h2);
    cmd(8'h35, 16'h0000, 2'h1);
    chk(rdata, 8'h28);
    chk({prot_top, param_top, 3'h0, prot}, 8'h05);
    cmd(8'h01, 16'h1404, 2'h2);
    chk(cfg, 8'h2C);
    chk({prot_top, param_top, prog_err, 5'h00}, 8'h60);
    cmd(8'h05, 16'h0000, 2'h1);
    chk(rdata & 8'h5C, 8'h54);
    cmd(8'hF0, 16'h0000, 2'h0);
    chk({5'h00, prot}, 8'h07);
    // lock set in the same write that clears the protect field
    cmd(8'h01, 16'h002D, 2'h2);
    chk({5'h00, prot}, 8'h00);
    cmd(8'h01, 16'h0800, 2'h2);
    chk({5'h00, prot}, 8'h00);
    cmd(8'hF0, 16'h0000, 2'h0);
    chk(cfg, 8'h2D);
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    cmd(8'h35, 16'h0000, 2'h1);
    chk(rdata, 8'h2C);
    chk({5'h00, prot}, 8'h07);
    wrap_up();
  end

  // watchdog: the sequence needs well under a tenth of this
  initial
  begin
    #400000;
    error_cnt++;
    wrap_up();
  end
endmodule
